// File: design/knsd_defines.vh
// constants for the knock sensor serial command decoder
`ifndef KNSD_DEFINES_VH
`define KNSD_DEFINES_VH

// ----------------------------------------
// command opcodes and masks
// ----------------------------------------
`define KNSD_CMD_ADVANCED   8'h71
`define KNSD_RSP_ADVANCED   8'h8E
`define KNSD_MASK_TWO       8'hC0
`define KNSD_MASK_THREE     8'hE0
`define KNSD_MASK_CHANNEL   8'hFE
`define KNSD_MASK_TEST      8'hF0
`define KNSD_PFX_BANDPASS   8'h00
`define KNSD_PFX_PRESCALE   8'h40
`define KNSD_PFX_GAIN       8'h80
`define KNSD_PFX_INTEG_TC   8'hC0
`define KNSD_PFX_CHANNEL    8'hE0
`define KNSD_PFX_TEST       8'hF0

// ----------------------------------------
// test command low nibbles
// ----------------------------------------
`define KNSD_TST_FILTER     4'h0
`define KNSD_TST_BUFFER     4'h2
`define KNSD_TST_CONV_BUF   4'h3
`define KNSD_TST_CONV_NOBUF 4'h4
`define KNSD_TST_CLAMP      4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define KNSD_PRESCALE_HI    4
`define KNSD_PRESCALE_LO    1
`define KNSD_HIZ_BIT        0

// ----------------------------------------
// reset values and the filter test clock pattern
// ----------------------------------------
`define KNSD_RST_PRESCALE   4'h0
`define KNSD_RST_BANDPASS   6'h00
`define KNSD_RST_GAIN       6'h00
`define KNSD_RST_INTEG_TC   5'h00
`define KNSD_RST_RESPONSE   8'h00
`define KNSD_CLOCK_PATTERN  8'hAA

`endif

// File: design/knsd_spi_shift.v
// serial frame shifter: pin synchronisers, 8-bit receive and transmit
`timescale 1ns/1ps
`default_nettype none

module knsd_spi_shift (
	input  wire       sys_clk,      // system clock
	input  wire       rst_n,        // async reset, active low
	input  wire       sclk_pin,     // serial clock from the processor
	input  wire       cs_n_pin,     // chip select, active low
	input  wire       mosi_pin,     // serial data in
	input  wire [7:0] tx_byte,      // reply for the frame now starting
	output reg  [7:0] rx_byte,      // last complete command byte
	output reg        rx_valid,     // one-cycle pulse per full byte
	output reg        frame_start,  // one-cycle pulse at select
	output reg        miso,         // serial data out
	output reg        selected      // chip select seen active
);

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	reg [2:0] sclk_reg;   // stage 0/1 sync, stage 2 edge history
	reg [2:0] cs_reg;     // same for select
	reg [1:0] mosi_reg;   // data needs no history
	reg [7:0] shift_reg;  // incoming bits
	reg [7:0] out_reg;    // outgoing bits
	reg [2:0] count_reg;  // bits taken in this byte

	wire sclk_rise = sclk_reg[1] & ~sclk_reg[2];
	wire sclk_fall = ~sclk_reg[1] & sclk_reg[2];
	wire cs_active = ~cs_reg[1];

	// pins pass two flops before any edge logic reads them
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_reg <= 3'b000;
			cs_reg   <= 3'b111;
			mosi_reg <= 2'b00;
		end else begin
			sclk_reg <= {sclk_reg[1:0], sclk_pin};
			cs_reg   <= {cs_reg[1:0], cs_n_pin};
			mosi_reg <= {mosi_reg[0], mosi_pin};
		end
	end

	// ----------------------------------------
	// shifting, msb first, sample rising, launch falling
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg   <= 8'h00;
			out_reg     <= 8'h00;
			count_reg   <= 3'd0;
			rx_byte     <= 8'h00;
			rx_valid    <= 1'b0;
			frame_start <= 1'b0;
			miso        <= 1'b0;
			selected    <= 1'b0;
		end else begin
			rx_valid    <= 1'b0;
			frame_start <= 1'b0;
			selected    <= cs_active;
			if (!cs_active) begin
				// deselected: realign to a byte boundary
				count_reg <= 3'd0;
			end else if (cs_reg[2] && !cs_reg[1]) begin
				// select edge: reply byte loaded, msb shown first
				frame_start <= 1'b1;
				out_reg     <= tx_byte;
				miso        <= tx_byte[7];
				count_reg   <= 3'd0;
			end else begin
				if (sclk_rise) begin
					shift_reg <= {shift_reg[6:0], mosi_reg[1]};
					count_reg <= count_reg + 3'd1;
					if (count_reg == 3'd7) begin
						rx_byte  <= {shift_reg[6:0], mosi_reg[1]};
						rx_valid <= 1'b1;
					end
				end
				if (sclk_fall) begin
					out_reg <= {out_reg[6:0], 1'b0};
					miso    <= out_reg[6];
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: design/knsd_cmd_decoder.v
// knock sensor serial command decoder with test mode routing
`timescale 1ns/1ps
`default_nettype none
`include "knsd_defines.vh"

module knsd_cmd_decoder (
	input  wire       sys_clk,              // 100 MHz system clock
	input  wire       rst_n,                // async reset, active low
	input  wire       spi_sclk,             // serial clock pin
	input  wire       spi_cs_n,             // chip select pin
	input  wire       spi_mosi,             // serial data in pin
	input  wire       test_n,               // diagnostic select pin, low = test
	input  wire       inline_sel,           // pin: pick in-line test variants
	input  wire       integrate_window,     // integrate/hold pin
	input  wire       oscillator_input,     // oscillator pin
	input  wire [9:0] integ_result,         // integrator result, same clock
	input  wire [7:0] converter_data,       // converter sample, same clock
	input  wire [2:0] clamp_flags,          // gain, band-pass, integrator clamps
	output reg        spi_miso,             // serial data out
	output reg        spi_miso_oe,          // high while driving data out
	output reg  [3:0] prescale_code,        // oscillator divider select
	output reg        channel_sel,          // 0 channel one, 1 channel two
	output reg  [5:0] bandpass_index,       // centre frequency index
	output reg  [5:0] gain_index,           // gain table index
	output reg  [4:0] integ_tc_index,       // integrator time constant index
	output reg        advanced_mode,        // advanced serial mode on
	output reg        input_amp_off,        // input amplifiers disabled
	output reg        output_amp_off,       // output amplifier disabled
	output reg        antialias_filter_off, // filter disabled
	output reg        antialias_in_fb,      // filter input from channel_one_feedback
	output reg        antialias_out_route,  // filter output onto analog out
	output reg        buffer_loop_open,     // output buffer feedback opened
	output reg        feedback_to_buffer,   // both feedback pins on buffer inputs
	output reg        converter_remap,      // window/osc pins feed converter
	output reg        converter_sync,       // converter frame sync
	output reg        converter_sclk,       // converter serial clock
	output reg  [7:0] dac_data,             // byte shifted in for the converter
	output reg        bandpass_gain_two,    // biquad stage gain fixed at 2
	output reg  [7:0] bandpass_q_x10        // biquad quality factor times ten
);

	// ----------------------------------------
	// test states, one-hot
	// ----------------------------------------
	localparam [7:0] TS_NONE      = 8'h01; // normal routing
	localparam [7:0] TS_FILTER    = 8'h02; // filter individual test
	localparam [7:0] TS_FILT_INL  = 8'h04; // filter in-line test
	localparam [7:0] TS_BUFFER    = 8'h08; // output buffer test
	localparam [7:0] TS_CONV_BUF  = 8'h10; // converter test with buffer
	localparam [7:0] TS_CONV_NOB  = 8'h20; // converter test without buffer
	localparam [7:0] TS_CONV_INL  = 8'h40; // converter in-line test
	localparam [7:0] TS_CLAMP     = 8'h80; // clamp flag read

	// biquad constants are fixed by the filter design
	localparam [7:0] BP_Q_X10 = 8'h17; // q of 2.3

	// ----------------------------------------
	// signals
	// ----------------------------------------
	wire [7:0] rx_byte;       // received command
	wire       rx_valid;      // command complete
	wire       frame_start;   // new frame begins
	wire       shift_miso;    // shifter data out
	wire       selected;      // select active

	reg  [1:0] test_sync;     // diagnostic pin sync
	reg  [1:0] inline_sync;   // in-line select sync
	reg  [1:0] window_sync;   // integrate window sync
	reg  [1:0] osc_sync;      // oscillator sync
	reg        sdo_hiz_reg;   // data out held in high impedance
	reg  [7:0] tstate_reg;    // test routing state
	reg  [7:0] tstate_next;   // next test routing state
	reg  [7:0] resp_reg;      // reply for next frame
	reg  [7:0] resp_next;     // next reply
	reg        hi_pending_reg; // second result byte still owed
	reg        hi_pending_next;
	reg        hi_queued_reg;  // high result byte already loaded for next frame
	reg        hi_queued_next;

	wire test_mode = ~test_sync[1];

	// ----------------------------------------
	// prefix match helper
	// ----------------------------------------
	function match;
		input [7:0] cmd;
		input [7:0] mask;
		input [7:0] prefix;
		begin
			match = ((cmd & mask) == prefix);
		end
	endfunction

	// ----------------------------------------
	// serial shifter
	// ----------------------------------------
	knsd_spi_shift u_shift (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.sclk_pin    (spi_sclk),
		.cs_n_pin    (spi_cs_n),
		.mosi_pin    (spi_mosi),
		.tx_byte     (resp_reg),
		.rx_byte     (rx_byte),
		.rx_valid    (rx_valid),
		.frame_start (frame_start),
		.miso        (shift_miso),
		.selected    (selected)
	);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// two flops for every asynchronous pin; only stage 1 is read
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			test_sync   <= 2'b11;
			inline_sync <= 2'b00;
			window_sync <= 2'b00;
			osc_sync    <= 2'b00;
		end else begin
			test_sync   <= {test_sync[0], test_n};
			inline_sync <= {inline_sync[0], inline_sel};
			window_sync <= {window_sync[0], integrate_window};
			osc_sync    <= {osc_sync[0], oscillator_input};
		end
	end

	// ----------------------------------------
	// test routing state and reply selection
	// ----------------------------------------
	always @* begin
		tstate_next     = tstate_reg;
		resp_next       = resp_reg;
		hi_pending_next = hi_pending_reg;
		hi_queued_next  = hi_queued_reg;
		if (!test_mode) begin
			// leaving test mode restores normal routing
			tstate_next = TS_NONE;
		end
		if (frame_start) begin
			// marks the one frame whose reply slot already holds bits 9:8
			hi_queued_next = hi_pending_reg;
		end
		if (frame_start && hi_pending_reg) begin
			// low byte went out; queue bits 9:8 then zeros
			resp_next       = {integ_result[9:8], 6'b00_0000};
			hi_pending_next = 1'b0;
		end
		if (rx_valid) begin
			if (hi_queued_reg) begin
				// every frame carries a command; it must not bump the high byte
				hi_pending_next = 1'b0;
			end else begin
				// default reply: result low byte, high byte next
				resp_next       = integ_result[7:0];
				hi_pending_next = 1'b1;
			end
			if (rx_byte == `KNSD_CMD_ADVANCED) begin
				resp_next       = `KNSD_RSP_ADVANCED;
				hi_pending_next = 1'b0;
			end else if (test_mode && match(rx_byte, `KNSD_MASK_TEST, `KNSD_PFX_TEST)) begin
				hi_pending_next = 1'b0;
				resp_next       = `KNSD_RST_RESPONSE;
				case (rx_byte[3:0])
					`KNSD_TST_FILTER: begin
						if (inline_sync[1]) begin
							tstate_next = TS_FILT_INL;
						end else begin
							tstate_next = TS_FILTER;
							resp_next   = `KNSD_CLOCK_PATTERN;
						end
					end
					`KNSD_TST_BUFFER: begin
						tstate_next = TS_BUFFER;
					end
					`KNSD_TST_CONV_BUF: begin
						tstate_next = inline_sync[1] ? TS_CONV_INL : TS_CONV_BUF;
						resp_next   = converter_data;
					end
					`KNSD_TST_CONV_NOBUF: begin
						tstate_next = TS_CONV_NOB;
						resp_next   = converter_data;
					end
					`KNSD_TST_CLAMP: begin
						tstate_next = TS_CLAMP;
						// flags only answer once advanced mode is on
						if (advanced_mode) begin
							resp_next = {5'b0_0000, clamp_flags};
						end
					end
					default: begin
						tstate_next = tstate_reg;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// state and reply registers
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tstate_reg     <= TS_NONE;
			resp_reg       <= `KNSD_RST_RESPONSE;
			hi_pending_reg <= 1'b0;
			hi_queued_reg  <= 1'b0;
		end else begin
			tstate_reg     <= tstate_next;
			resp_reg       <= resp_next;
			hi_pending_reg <= hi_pending_next;
			hi_queued_reg  <= hi_queued_next;
		end
	end

	// ----------------------------------------
	// normal command decoding
	// ----------------------------------------
	// exact advanced opcode wins over the prescaler prefix it shares
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_code  <= `KNSD_RST_PRESCALE;
			sdo_hiz_reg    <= 1'b0;
			channel_sel    <= 1'b0;
			bandpass_index <= `KNSD_RST_BANDPASS;
			gain_index     <= `KNSD_RST_GAIN;
			integ_tc_index <= `KNSD_RST_INTEG_TC;
			advanced_mode  <= 1'b0;
		end else if (rx_valid) begin
			if (rx_byte == `KNSD_CMD_ADVANCED) begin
				advanced_mode <= 1'b1;
			end else if (test_mode && match(rx_byte, `KNSD_MASK_TEST, `KNSD_PFX_TEST)) begin
				// test opcodes touch no configuration
				advanced_mode <= advanced_mode;
			end else if (match(rx_byte, `KNSD_MASK_TWO, `KNSD_PFX_BANDPASS)) begin
				bandpass_index <= rx_byte[5:0];
			end else if (match(rx_byte, `KNSD_MASK_TWO, `KNSD_PFX_PRESCALE)) begin
				prescale_code <= rx_byte[`KNSD_PRESCALE_HI:`KNSD_PRESCALE_LO];
				sdo_hiz_reg   <= rx_byte[`KNSD_HIZ_BIT];
			end else if (match(rx_byte, `KNSD_MASK_TWO, `KNSD_PFX_GAIN)) begin
				gain_index <= rx_byte[5:0];
			end else if (match(rx_byte, `KNSD_MASK_THREE, `KNSD_PFX_INTEG_TC)) begin
				integ_tc_index <= rx_byte[4:0];
			end else if (match(rx_byte, `KNSD_MASK_CHANNEL, `KNSD_PFX_CHANNEL)) begin
				channel_sel <= rx_byte[0];
			end
		end
	end

	// ----------------------------------------
	// analog routing controls from test state
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_amp_off        <= 1'b0;
			output_amp_off       <= 1'b0;
			antialias_filter_off <= 1'b0;
			antialias_in_fb      <= 1'b0;
			antialias_out_route  <= 1'b0;
			buffer_loop_open     <= 1'b0;
			feedback_to_buffer   <= 1'b0;
			converter_remap      <= 1'b0;
		end else begin
			input_amp_off        <= tstate_reg[1] | tstate_reg[3]
			                        | tstate_reg[4] | tstate_reg[5];
			output_amp_off       <= tstate_reg[1] | tstate_reg[2] | tstate_reg[5];
			antialias_filter_off <= tstate_reg[3] | tstate_reg[4] | tstate_reg[5];
			antialias_in_fb      <= tstate_reg[1];
			antialias_out_route  <= tstate_reg[1] | tstate_reg[2];
			buffer_loop_open     <= tstate_reg[3];
			feedback_to_buffer   <= tstate_reg[3];
			converter_remap      <= tstate_reg[4] | tstate_reg[5] | tstate_reg[6];
		end
	end

	// ----------------------------------------
	// converter pin remap and dac byte
	// ----------------------------------------
	// remapped pins lag by the sync stages; fine for test use only
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_sync <= 1'b0;
			converter_sclk <= 1'b0;
			dac_data       <= 8'h00;
		end else begin
			converter_sync <= converter_remap & window_sync[1];
			converter_sclk <= converter_remap & osc_sync[1];
			if (rx_valid && converter_remap) begin
				dac_data <= rx_byte;
			end
		end
	end

	// ----------------------------------------
	// band-pass stage constants and data out
	// ----------------------------------------
	// the biquad itself is analog; only its fixed gain and q leave here
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bandpass_gain_two <= 1'b0;
			bandpass_q_x10    <= 8'h00;
			spi_miso          <= 1'b0;
			spi_miso_oe       <= 1'b0;
		end else begin
			bandpass_gain_two <= 1'b1;
			bandpass_q_x10    <= BP_Q_X10;
			spi_miso          <= shift_miso;
			// silent tests still drive the line, shifting out zeros
			spi_miso_oe       <= selected & ~sdo_hiz_reg;
		end
	end

endmodule

`default_nettype wire

// File: bench/knsd_spi_master.sv
// serial master model standing in for the engine controller
`timescale 1ns/1ps
`default_nettype none

module knsd_spi_master (
	input  wire logic sys_clk,  // system clock, drives all timing
	input  wire logic miso,     // device serial data out
	input  wire logic miso_oe,  // device drives data out
	output var  logic sclk,     // serial clock, idle low
	output var  logic cs_n,     // select, active low
	output var  logic mosi,     // data to the device
	output var  logic oe_seen   // data out driven during last frame
);
	// idle: deselected, clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		oe_seen = 1'b0;
	end

	// ------------------------------
	// one byte per select, msb first
	// ------------------------------
	// eight clocks per half bit keeps well inside the synchroniser limit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		@(posedge sys_clk);
		cs_n <= 1'b0;
		mosi <= tx[7];
		oe_seen <= 1'b0;
		repeat (8) @(posedge sys_clk);
		for (i = 7; i >= 0; i--) begin
			sclk <= 1'b1;
			rx[i] = miso;                   // sampled on the rising edge
			oe_seen <= oe_seen | miso_oe;
			repeat (8) @(posedge sys_clk);
			sclk <= 1'b0;
			// next bit launched on the falling edge, settled before the rise
			// after the last bit the line shows junk, not a held value
			mosi <= (i > 0) ? tx[i - 1] : ~tx[0];
			repeat (8) @(posedge sys_clk);
		end
		cs_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule

`default_nettype wire

// File: bench/knsd_cmd_decoder_chk.sv
// port-level assertions for the command decoder
`timescale 1ns/1ps
`default_nettype none

module knsd_cmd_decoder_chk (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       spi_cs_n,
	input wire logic       test_n,
	input wire logic       integrate_window,
	input wire logic       oscillator_input,
	input wire logic       spi_miso_oe,
	input wire logic [3:0] prescale_code,
	input wire logic       channel_sel,
	input wire logic [5:0] bandpass_index,
	input wire logic [5:0] gain_index,
	input wire logic [4:0] integ_tc_index,
	input wire logic       advanced_mode,
	input wire logic       input_amp_off,
	input wire logic       output_amp_off,
	input wire logic       antialias_filter_off,
	input wire logic       antialias_in_fb,
	input wire logic       antialias_out_route,
	input wire logic       buffer_loop_open,
	input wire logic       feedback_to_buffer,
	input wire logic       converter_remap,
	input wire logic       converter_sync,
	input wire logic       converter_sclk,
	input wire logic       bandpass_gain_two,
	input wire logic [7:0] bandpass_q_x10
);
	// grouped views of settings and analog routing
	wire [21:0] cfg_vec = {prescale_code, channel_sel, bandpass_index, gain_index, integ_tc_index};
	wire [7:0]  route_vec = {input_amp_off, output_amp_off, antialias_filter_off, antialias_in_fb,
		antialias_out_route, buffer_loop_open, feedback_to_buffer, converter_remap};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------
	// serial link and settings
	// ------------------------------
	a_oe_idle: assert property (spi_cs_n [*8] |-> !spi_miso_oe)
		else $error("data out driven while deselected");
	a_cfg_hold: assert property (spi_cs_n [*8] |=> $stable(cfg_vec))
		else $error("settings changed with no frame");
	a_adv_sticky: assert property (advanced_mode |=> advanced_mode)
		else $error("advanced mode dropped");
	a_bp_const: assert property ($past(rst_n) |-> bandpass_gain_two && bandpass_q_x10 == 8'h17)
		else $error("band-pass constants wrong");

	// ------------------------------
	// test routing
	// ------------------------------
	a_test_gate: assert property (test_n [*8] |-> route_vec == 8'h00)
		else $error("test routing active outside test mode");
	a_filter_chain: assert property (antialias_in_fb |-> input_amp_off && output_amp_off && antialias_out_route)
		else $error("filter test routing incomplete");
	a_buffer_test: assert property (buffer_loop_open |-> feedback_to_buffer && input_amp_off && antialias_filter_off)
		else $error("buffer test routing incomplete");
	a_nobuf_chain: assert property (converter_remap && output_amp_off |-> input_amp_off && antialias_filter_off)
		else $error("converter test without buffer leaves chain on");
	a_sync_follow: assert property ((converter_remap && $stable(integrate_window)) [*6] |-> converter_sync == integrate_window)
		else $error("converter sync does not follow window pin");
	a_sclk_follow: assert property ((converter_remap && $stable(oscillator_input)) [*6] |-> converter_sclk == oscillator_input)
		else $error("converter clock does not follow oscillator pin");
	a_remap_quiet: assert property (!converter_remap [*3] |-> !converter_sync && !converter_sclk)
		else $error("converter pins active without remap");

	// main scenarios reached
	cover property ($rose(advanced_mode));
	cover property (antialias_in_fb);
	cover property (buffer_loop_open);
	cover property (converter_remap && converter_sync);
endmodule

bind knsd_cmd_decoder knsd_cmd_decoder_chk u_chk (.sys_clk, .rst_n, .spi_cs_n, .test_n,
	.integrate_window, .oscillator_input, .spi_miso_oe, .prescale_code, .channel_sel,
	.bandpass_index, .gain_index, .integ_tc_index, .advanced_mode, .input_amp_off,
	.output_amp_off, .antialias_filter_off, .antialias_in_fb, .antialias_out_route,
	.buffer_loop_open, .feedback_to_buffer, .converter_remap, .converter_sync,
	.converter_sclk, .bandpass_gain_two, .bandpass_q_x10);

`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none

`define KNSD_CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("FAIL %s exp %0h got %0h", nm, exp, got); end end

module tb_top;
	logic       sys_clk = 1'b0;
	logic       rst_n, test_n, inline_sel, integrate_window, oscillator_input;
	logic [9:0] integ_result;
	logic [7:0] converter_data, dac_data, bandpass_q_x10;
	logic [2:0] clamp_flags;
	logic       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, oe_seen;
	logic [3:0] prescale_code;
	logic [5:0] bandpass_index, gain_index;
	logic [4:0] integ_tc_index;
	logic       channel_sel, advanced_mode, input_amp_off, output_amp_off, antialias_filter_off;
	logic       antialias_in_fb, antialias_out_route, buffer_loop_open, feedback_to_buffer;
	logic       converter_remap, converter_sync, converter_sclk, bandpass_gain_two;
	int         mismatches = 0;
	int         check_count = 0;
	// routing flags packed for table compares
	wire [7:0]  route_vec = {input_amp_off, output_amp_off, antialias_filter_off, antialias_in_fb,
		antialias_out_route, buffer_loop_open, feedback_to_buffer, converter_remap};

	always #5 sys_clk = ~sys_clk;

	knsd_cmd_decoder dut (.sys_clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .test_n, .inline_sel,
		.integrate_window, .oscillator_input, .integ_result, .converter_data, .clamp_flags,
		.spi_miso, .spi_miso_oe, .prescale_code, .channel_sel, .bandpass_index, .gain_index,
		.integ_tc_index, .advanced_mode, .input_amp_off, .output_amp_off, .antialias_filter_off,
		.antialias_in_fb, .antialias_out_route, .buffer_loop_open, .feedback_to_buffer,
		.converter_remap, .converter_sync, .converter_sclk, .dac_data, .bandpass_gain_two,
		.bandpass_q_x10);

	knsd_spi_master u_mst (.sys_clk, .miso(spi_miso), .miso_oe(spi_miso_oe), .sclk(spi_sclk),
		.cs_n(spi_cs_n), .mosi(spi_mosi), .oe_seen);

	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic stop_test();
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// hi-z bit keeps data out silent until a prescaler byte clears it
	task automatic t_prescale();
		logic [7:0] r;
		`KNSD_CHK("gain_two", 1'b1, bandpass_gain_two)
		`KNSD_CHK("q_x10", 8'h17, bandpass_q_x10)
		u_mst.xfer(8'h45, r);
		`KNSD_CHK("prescale_code", 4'h2, prescale_code)
		u_mst.xfer(8'h44, r);
		`KNSD_CHK("oe_hiz", 1'b0, oe_seen)
		u_mst.xfer(8'h27, r);
		`KNSD_CHK("oe_clear", 1'b1, oe_seen)
	endtask

	// field commands, top index first
	task automatic t_config();
		logic [7:0] r;
		u_mst.xfer(8'h3F, r);
		`KNSD_CHK("bandpass_max", 6'h3F, bandpass_index)
		u_mst.xfer(8'h27, r);
		`KNSD_CHK("bandpass_index", 6'h27, bandpass_index)
		u_mst.xfer(8'h94, r);
		`KNSD_CHK("gain_index", 6'h14, gain_index)
		u_mst.xfer(8'hC3, r);
		`KNSD_CHK("integ_tc_index", 5'h03, integ_tc_index)
		u_mst.xfer(8'hE1, r);
		`KNSD_CHK("channel_sel", 1'b1, channel_sel)
	endtask

	// result comes back low byte first, then high bits padded
	task automatic t_result();
		logic [7:0] r;
		@(posedge sys_clk);
		integ_result <= 10'h2A5;
		u_mst.xfer(8'hE1, r);
		u_mst.xfer(8'hE1, r);
		`KNSD_CHK("result_low", 8'hA5, r)
		u_mst.xfer(8'hE1, r);
		`KNSD_CHK("result_high", 8'h80, r)
	endtask

	// clamp read, reply fetched by an ignored test byte
	task automatic t_clamp(input logic [2:0] f, input logic [7:0] e);
		logic [7:0] r;
		@(posedge sys_clk);
		test_n <= 1'b0;
		clamp_flags <= f;
		u_mst.xfer(8'hF8, r);
		u_mst.xfer(8'hF1, r);
		`KNSD_CHK("clamp_reply", e, r)
	endtask

	task automatic t_adv();
		logic [7:0] r;
		u_mst.xfer(8'h71, r);
		u_mst.xfer(8'hF1, r);
		`KNSD_CHK("adv_reply", 8'h8E, r)
		`KNSD_CHK("adv_mode", 1'b1, advanced_mode)
	endtask

	// every test code but clamp, plain and in-line
	task automatic t_route();
		logic [7:0] r;
		int i;
		logic [7:0] cm [6] = '{8'hF0, 8'hF0, 8'hF2, 8'hF3, 8'hF4, 8'hF3};
		logic       il [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		logic [7:0] ex [6] = '{8'hD8, 8'h48, 8'hA6, 8'hA1, 8'hE1, 8'h01};
		logic [7:0] rp [6] = '{8'hAA, 8'h00, 8'h00, 8'h6C, 8'h6C, 8'h6C};
		@(posedge sys_clk);
		converter_data <= 8'h6C;
		integrate_window <= 1'b1;
		oscillator_input <= 1'b1;
		for (i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			inline_sel <= il[i];
			u_mst.xfer(cm[i], r);
			`KNSD_CHK("routing", ex[i], route_vec)
			if (ex[i][0]) `KNSD_CHK("conv_pins", 2'b11, {converter_sync, converter_sclk})
			u_mst.xfer(8'hF1, r);
			`KNSD_CHK("test_reply", rp[i], r)
			if (ex[i][0]) `KNSD_CHK("dac_data", 8'hF1, dac_data)
		end
		@(posedge sys_clk);
		integrate_window <= 1'b0;
		oscillator_input <= 1'b0;
		repeat (8) @(posedge sys_clk);
		`KNSD_CHK("conv_pins_low", 2'b00, {converter_sync, converter_sclk})
	endtask

	// test codes are refused once the diagnostic pin goes high
	task automatic t_gate();
		logic [7:0] r;
		@(posedge sys_clk);
		test_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		`KNSD_CHK("route_normal", 8'h00, route_vec)
		u_mst.xfer(8'hF0, r);
		`KNSD_CHK("route_refused", 8'h00, route_vec)
		`KNSD_CHK("channel_kept", 1'b1, channel_sel)
	endtask

	// ------------------------------
	// main sequence and watchdog
	// ------------------------------
	initial begin
		rst_n = 1'b0;
		test_n = 1'b1;
		inline_sel = 1'b0;
		integrate_window = 1'b0;
		oscillator_input = 1'b0;
		integ_result = 10'h000;
		converter_data = 8'h00;
		clamp_flags = 3'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_prescale();
		t_config();
		t_result();
		t_clamp(3'h5, 8'h00);
		t_adv();
		t_clamp(3'h5, 8'h05);
		t_clamp(3'h2, 8'h02);
		t_route();
		t_gate();
		stop_test();
	end

	// about 32 frames of 145 clocks each; generous margin
	initial begin
		#500000;
		mismatches++;
		stop_test();
	end
endmodule

`default_nettype wire
